// File: core/atsd_dither.sv
`timescale 1ns/1ps
`default_nettype none
`include "atsd_map.svh"

module atsd_dither #(
	parameter int SAMPLE_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// control
	input wire atsd_pkg::atsd_dith_t cfg,
	// samples
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_in,
	output logic [SAMPLE_W-1:0] sample_out,
	output logic [11:0] dither_value
);
	logic [15:0] lfsr_q;
	logic [11:0] dith_raw;
	logic [11:0] dith_mask;
	logic [SAMPLE_W:0] diff;
	logic [SAMPLE_W-1:0] rounded;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lfsr_q <= 16'hACE1;
		else if (clk_en && sample_valid)
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end

	// amplitude picks the mask width
	always_comb
	begin
		dith_mask = cfg.amp_large ? `ATSD_DITH_LARGE_MASK : `ATSD_DITH_SMALL_MASK;
		dith_raw = cfg.enable ? (lfsr_q[11:0] & dith_mask) : 12'h000;
		// analog path adds dither; digital side removes it again
		diff = {1'b0, sample_in} - {1'b0, SAMPLE_W'(dith_raw)};
		// rounding: lsb forced (dc/spur) or truncate (noise)
		if (cfg.err_to_dc)
			rounded = {diff[SAMPLE_W-1:1], 1'b1};
		else
			rounded = diff[SAMPLE_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sample_out <= '0;
			dither_value <= 12'h000;
		end
		else if (clk_en && sample_valid)
		begin
			sample_out <= cfg.enable ? rounded : sample_in;
			dither_value <= dith_raw;
		end
	end

	dith_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && sample_valid && !cfg.enable) |=> (dither_value == 12'h000))
		else $error("dither injected while disabled");
endmodule : atsd_dither
`default_nettype wire

// File: core/atsd_map.svh
`ifndef ATSD_MAP_SVH
`define ATSD_MAP_SVH

// register indices; byte address is four times the index
`define ATSD_IDX_TRIM_B 12'h07F
`define ATSD_IDX_TRIM_C 12'h080
`define ATSD_IDX_TRIM_D 12'h081
`define ATSD_IDX_SRC_DLY 12'h09A
`define ATSD_IDX_SEL_DLY 12'h09B
`define ATSD_IDX_DITH 12'h09D
`define ATSD_IDX_SWAP_CTRL 12'h0A0
`define ATSD_IDX_STATUS 12'h0A1

`define ATSD_RST_SRC_DLY 5'h08
`define ATSD_RST_SEL_DLY 5'h07
`define ATSD_RST_DITH 3'h0

`define ATSD_DITH_EN_BIT 0
`define ATSD_DITH_AMP_BIT 1
`define ATSD_DITH_ERR_BIT 2

`define ATSD_OVL_BASE 7'h04
`define ATSD_DITH_SMALL_MASK 12'h007
`define ATSD_DITH_LARGE_MASK 12'h03F

`endif

// File: core/atsd_pkg.sv
package atsd_pkg;
	typedef struct packed {
		logic [7:0] trim_b;
		logic [7:0] trim_c;
		logic [7:0] trim_d;
	} atsd_trim_t;

	typedef struct packed {
		logic enable;
		logic amp_large;
		logic err_to_dc;
	} atsd_dith_t;

	typedef enum logic [1:0] {
		ATSD_IDLE,
		ATSD_OVERLAP,
		ATSD_STEER
	} atsd_swap_t;
endpackage : atsd_pkg

// File: core/atsd_regs.sv
// Notes on behaviour
// - trim registers for inputs b, c, d are 8-bit read/write
// - trim defaults come from fuse storage once fuse_valid is seen after reset (zero until then)
// - overlap delay is 5 bits, resets to 0x08, range 0..31
// - swap overlap lasts 4 + 2*overlap delay core cycles
// - steering delay 5 bits, reset 0x07, delays mux select during swaps
// - dither control bit 0 enables dither injection
// - dither control bit 1 selects large amplitude
// - dither control bit 2 routes rounding error to dc and spurs
`timescale 1ns/1ps
`default_nettype none
`include "atsd_map.svh"

module atsd_regs #(
	parameter int SAMPLE_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// fuse storage
	input wire atsd_pkg::atsd_trim_t fuse_trim,
	input wire logic fuse_valid,
	// calibration
	input wire logic cal_enable,
	input wire logic swap_request,
	// swap controls
	output logic swap_overlap,
	output logic steer_select,
	output logic swap_busy,
	output atsd_pkg::atsd_trim_t trim_out,
	// samples
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_in,
	output logic [SAMPLE_W-1:0] sample_out
);
	atsd_pkg::atsd_trim_t trim_q;
	atsd_pkg::atsd_dith_t dith_q;
	atsd_pkg::atsd_swap_t state_q;
	logic [4:0] src_dly_q;
	logic [4:0] sel_dly_q;
	logic [6:0] cnt_q;
	logic [6:0] ovl_len;
	logic fuse_s1_q;
	logic fuse_s2_q;
	logic fuse_done_q;
	logic req_s1_q;
	logic req_s2_q;
	logic req_prev_q;
	logic cal_s1_q;
	logic cal_s2_q;
	logic sw_req_q;
	logic swap_start;
	logic [11:0] idx;
	logic wr;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic [11:0] dith_dbg;

	assign idx = paddr[13:2];
	assign wr = psel && penable && pwrite && pstrb[0] && clk_en;
	assign pready = 1'b1;
	assign ovl_len = `ATSD_OVL_BASE + {1'b0, src_dly_q, 1'b0};

	// pin inputs synchronised
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fuse_s1_q <= 1'b0;
			fuse_s2_q <= 1'b0;
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_prev_q <= 1'b0;
			cal_s1_q <= 1'b0;
			cal_s2_q <= 1'b0;
		end
		else if (clk_en)
		begin
			fuse_s1_q <= fuse_valid;
			fuse_s2_q <= fuse_s1_q;
			req_s1_q <= swap_request;
			req_s2_q <= req_s1_q;
			req_prev_q <= req_s2_q;
			cal_s1_q <= cal_enable;
			cal_s2_q <= cal_s1_q;
		end
	end

	// trims: fuse image loaded once after reset, then software owns them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trim_q <= '0;
			fuse_done_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!fuse_done_q && fuse_s2_q)
			begin
				trim_q <= fuse_trim;
				fuse_done_q <= 1'b1;
			end
			else if (wr && idx == `ATSD_IDX_TRIM_B)
				trim_q.trim_b <= pwdata[7:0];
			else if (wr && idx == `ATSD_IDX_TRIM_C)
				trim_q.trim_c <= pwdata[7:0];
			else if (wr && idx == `ATSD_IDX_TRIM_D)
				trim_q.trim_d <= pwdata[7:0];
		end
	end

	// delay registers; reserved bits dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_dly_q <= `ATSD_RST_SRC_DLY;
			sel_dly_q <= `ATSD_RST_SEL_DLY;
		end
		else if (clk_en)
		begin
			if (wr && idx == `ATSD_IDX_SRC_DLY)
				src_dly_q <= pwdata[4:0];
			else if (wr && idx == `ATSD_IDX_SEL_DLY)
				sel_dly_q <= pwdata[4:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dith_q <= `ATSD_RST_DITH;
		else if (clk_en && wr && idx == `ATSD_IDX_DITH)
		begin
			dith_q.enable <= pwdata[`ATSD_DITH_EN_BIT];
			dith_q.amp_large <= pwdata[`ATSD_DITH_AMP_BIT];
			dith_q.err_to_dc <= pwdata[`ATSD_DITH_ERR_BIT];
		end
	end

	// software swap trigger: self-clearing, set wins over consumption
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sw_req_q <= 1'b0;
		else if (clk_en)
		begin
			if (wr && idx == `ATSD_IDX_SWAP_CTRL && pwdata[0])
				sw_req_q <= 1'b1;
			else if (swap_start)
				sw_req_q <= 1'b0;
		end
	end

	assign swap_start = (state_q == atsd_pkg::ATSD_IDLE) && cal_s2_q
		&& ((req_s2_q && !req_prev_q) || sw_req_q);

	// swap sequencer: overlap only; the delayed steering switch falls inside it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= atsd_pkg::ATSD_IDLE;
			cnt_q <= 7'h00;
		end
		else if (clk_en)
		begin
			case (state_q)
				atsd_pkg::ATSD_IDLE:
				begin
					if (swap_start)
					begin
						state_q <= atsd_pkg::ATSD_OVERLAP;
						cnt_q <= 7'h01;
					end
				end
				atsd_pkg::ATSD_OVERLAP:
				begin
					if (cnt_q >= ovl_len)
					begin
						state_q <= atsd_pkg::ATSD_IDLE;
						cnt_q <= 7'h00;
					end
					else
						cnt_q <= cnt_q + 7'h01;
				end
				default:
				begin
					state_q <= atsd_pkg::ATSD_IDLE;
					cnt_q <= 7'h00;
				end
			endcase
		end
	end

	// steering flips sel_dly + 1 cycles after overlap start if sel_dly + 1 <= ovl_len, else not at all (only during swaps)
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			steer_select <= 1'b0;
		else if (clk_en && state_q == atsd_pkg::ATSD_OVERLAP
			&& cnt_q == {2'b00, sel_dly_q} + 7'h01)
			steer_select <= ~steer_select;
	end

	assign swap_overlap = (state_q == atsd_pkg::ATSD_OVERLAP);
	assign swap_busy = swap_overlap;
	assign trim_out = trim_q;

	// read mux
	always_comb
	begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		if (idx == `ATSD_IDX_TRIM_B)
			rd_byte = trim_q.trim_b;
		else if (idx == `ATSD_IDX_TRIM_C)
			rd_byte = trim_q.trim_c;
		else if (idx == `ATSD_IDX_TRIM_D)
			rd_byte = trim_q.trim_d;
		else if (idx == `ATSD_IDX_SRC_DLY)
			rd_byte = {3'h0, src_dly_q};
		else if (idx == `ATSD_IDX_SEL_DLY)
			rd_byte = {3'h0, sel_dly_q};
		else if (idx == `ATSD_IDX_DITH)
			rd_byte = {5'h00, dith_q.err_to_dc, dith_q.amp_large, dith_q.enable};
		else if (idx == `ATSD_IDX_SWAP_CTRL)
			rd_byte = {7'h00, sw_req_q};
		else if (idx == `ATSD_IDX_STATUS)
			rd_byte = {5'h00, fuse_done_q, steer_select, swap_busy};
		else
			rd_hit = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && !penable && !pwrite)
			prdata <= {24'h00_0000, rd_byte};
	end

	assign pslverr = psel && penable && !rd_hit;

	atsd_dither #(
		.SAMPLE_W(SAMPLE_W)
	) u_dither (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.cfg(dith_q),
		.sample_valid(sample_valid),
		.sample_in(sample_in),
		.sample_out(sample_out),
		.dither_value(dith_dbg)
	);

	ovl_length_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && swap_overlap && cnt_q == ovl_len) |=> !swap_overlap)
		else $error("overlap length wrong");
	src_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> src_dly_q == 5'h08)
		else $error("overlap delay reset value wrong");
	src_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && idx == 12'h09A) |=> src_dly_q == $past(pwdata[4:0]))
		else $error("overlap delay write lost");
	sel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && idx == 12'h09B) |=> sel_dly_q == $past(pwdata[4:0]))
		else $error("steering delay write lost");
	steer_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!swap_overlap |=> $stable(steer_select))
		else $error("steering moved outside swap");
	trim_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && fuse_done_q && idx == 12'h080) |=> trim_q.trim_c == $past(pwdata[7:0]))
		else $error("trim write lost");
	fuse_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && !fuse_done_q && fuse_s2_q) |=> trim_q == $past(fuse_trim))
		else $error("fuse image not loaded");
	dith_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && idx == `ATSD_IDX_DITH) |=> {dith_q.err_to_dc, dith_q.amp_large, dith_q.enable}
		== $past(pwdata[2:0]))
		else $error("dither control write lost");
	dith_sub_a: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && sample_valid && !dith_q.enable) |=> sample_out == $past(sample_in))
		else $error("sample altered without dither");
endmodule : atsd_regs
`default_nettype wire

// File: tb/atsd_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "atsd_map.svh"

module testbench;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, cal_enable, swap_request, fuse_valid, sample_valid;
	logic pready, pslverr, swap_overlap, steer_select, swap_busy, err, tog, lsb_ok;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	atsd_pkg::atsd_trim_t fuse_trim, trim_out;
	logic [11:0] sample_in, sample_out, diff, dmax;
	logic [11:0] tidx [3] = '{`ATSD_IDX_TRIM_B, `ATSD_IDX_TRIM_C, `ATSD_IDX_TRIM_D};
	logic [4:0] dlys [3] = '{5'h00, 5'h07, 5'h1F};
	logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h3, 3'h5};
	int err_total = 0;
	int n_compared = 0;
	int k;
	int len;

	always #25 pclk = ~pclk;

	atsd_regs #(.SAMPLE_W(12)) i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fuse_trim(fuse_trim), .fuse_valid(fuse_valid), .cal_enable(cal_enable),
		.swap_request(swap_request), .swap_overlap(swap_overlap), .steer_select(steer_select),
		.swap_busy(swap_busy), .trim_out(trim_out), .sample_valid(sample_valid),
		.sample_in(sample_in), .sample_out(sample_out));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask : rd_chk

	// swap with the overlap delay changed only while calibration is off
	task automatic swap(input logic [4:0] dly, input logic cal);
		logic s0;
		cal_enable <= 1'b0;
		xfer(1'b1, `ATSD_IDX_SRC_DLY, {27'h0, dly});
		cal_enable <= cal;
		repeat (4) @(posedge pclk);
		s0 = steer_select;
		swap_request <= 1'b1;
		k = 0;
		len = 0;
		while (swap_overlap !== 1'b1 && k < 20)
		begin
			@(negedge pclk);
			k++;
		end
		while (swap_overlap === 1'b1 && len < 100)
		begin
			@(negedge pclk);
			len++;
		end
		tog = steer_select ^ s0;
		swap_request <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : swap

	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	initial
	begin
		repeat (5000) @(posedge pclk);
		err_total++;
		conclude();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, cal_enable, swap_request, fuse_valid} = 7'h0;
		paddr = 14'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		fuse_trim = 24'hA53C96;
		sample_valid = 1'b1;
		sample_in = 12'h800;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`ATSD_IDX_SRC_DLY, 32'h08);
		rd_chk(`ATSD_IDX_SEL_DLY, 32'h07);
		rd_chk(`ATSD_IDX_DITH, 32'h0);
		for (int i = 0; i < 3; i++)
			rd_chk(tidx[i], 32'h0);
		fuse_valid <= 1'b1;
		k = 0;
		do
		begin
			xfer(1'b0, `ATSD_IDX_STATUS, 32'h0);
			k++;
		end
		while (rd[2] !== 1'b1 && k < 20);
		chk(rd[2], 1'b1);
		rd_chk(tidx[0], 32'hA5);
		rd_chk(tidx[1], 32'h3C);
		rd_chk(tidx[2], 32'h96);
		chk(trim_out, 24'hA53C96);
		for (int i = 0; i < 3; i++)
			xfer(1'b1, tidx[i], 32'hFFFF_FF00 | (32'h11 << i));
		for (int i = 0; i < 3; i++)
			rd_chk(tidx[i], 32'h11 << i);
		chk(trim_out, 24'h112244);
		xfer(1'b1, `ATSD_IDX_SRC_DLY, 32'h0000_001F);
		rd_chk(`ATSD_IDX_SRC_DLY, 32'h1F);
		xfer(1'b1, `ATSD_IDX_SEL_DLY, 32'h0000_0002);
		rd_chk(`ATSD_IDX_SEL_DLY, 32'h02);
		xfer(1'b1, `ATSD_IDX_DITH, 32'h0000_0007);
		rd_chk(`ATSD_IDX_DITH, 32'h07);
		xfer(1'b1, 12'h082, 32'hFFFF_FFFF);
		chk(err, 1'b1);
		rd_chk(12'h082, 32'h0);
		chk(err, 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			swap(dlys[i], 1'b1);
			chk(len, 4 + 2 * dlys[i]);
			chk(tog, 1'b1);
		end
		swap(5'h03, 1'b0);
		chk(len, 0);
		chk(tog, 1'b0);
		// software-triggered swap through the control register
		cal_enable <= 1'b1;
		repeat (4) @(posedge pclk);
		xfer(1'b1, `ATSD_IDX_SWAP_CTRL, 32'h1);
		xfer(1'b0, `ATSD_IDX_STATUS, 32'h0);
		chk(rd[0], 1'b1);
		chk(swap_busy, 1'b1);
		repeat (20) @(posedge pclk);
		chk(swap_busy, 1'b0);
		rd_chk(`ATSD_IDX_SWAP_CTRL, 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			xfer(1'b1, `ATSD_IDX_DITH, {29'h0, modes[m]});
			repeat (3) @(negedge pclk);
			dmax = 12'h0;
			lsb_ok = 1'b1;
			repeat (40)
			begin
				@(negedge pclk);
				diff = 12'h800 - sample_out;
				lsb_ok = lsb_ok & sample_out[0];
				if (diff > dmax)
					dmax = diff;
			end
			if (m == 0)
				chk(dmax, 12'h0);
			if (m == 1)
				chk(dmax > 12'h0 && dmax <= 12'h007, 1'b1);
			if (m == 2)
				chk(dmax > 12'h007 && dmax <= 12'h03F, 1'b1);
			if (m == 3)
				chk(lsb_ok, 1'b1);
		end
		conclude();
	end
endmodule : testbench
`default_nettype wire
